/* sim/arr_regs_monitor.sv */
// assertions on the bus side and capture outputs of the register slice
// assumes binding to arr_regs; one clock, sync active-high reset
`timescale 1ns/1ns
module arr_regs_monitor
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic conv_start,
  input wire logic [3:0] range_code,
  input wire logic internal_reference_disable,
  input wire logic range_valid,
  input wire logic range_bipolar,
  input wire logic overall_alarm,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_alm = pready && !pwrite && paddr == 8'h20 && !pslverr;
  AST_RDY: assert property (psel && !penable && !pready && ce |=> pready)
    else $error("setup not answered");
  AST_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_ERRRDY: assert property (pslverr |-> pready) else $error("error without ready");
  AST_ERR: assert property (pready && !(paddr inside {8'h14, 8'h20, 8'h30, 8'h34})
    |-> pslverr && prdata == 32'h0) else $error("unmapped access");
  AST_RNG_RSV: assert property (pready && !pwrite && paddr == 8'h14
    |-> (prdata & 32'hFFFFFFB0) == 32'h0) else $error("range reserved bits");
  AST_ALM_RSV: assert property (rd_alm |-> (prdata & 32'hFFFF330E) == 32'h0)
    else $error("alarm reserved bits");
  AST_OVR: assert property (rd_alm |-> prdata[0] == |prdata[7:4])
    else $error("overall alarm mismatch");
  AST_CAP: assert property (!conv_start |=> $stable(range_code)
    && $stable(internal_reference_disable)) else $error("range changed without start");
  AST_BIP: assert property (range_bipolar == !range_code[3])
    else $error("bipolar flag wrong");
  AST_VLD: assert property (range_valid == (range_code <= 4'h4 || range_code inside {[4'h8:4'hB]}))
    else $error("valid flag wrong");
  AST_STICKY: assert property (overall_alarm |=> overall_alarm)
    else $error("latched alarm lost");
  AST_RST: assert property ($fell(rst) |-> !overall_alarm && !irq && range_code == 4'h0)
    else $error("bad reset state");
  cover property (rd_alm && prdata[0]);
  cover property (pslverr);
  cover property ($rose(irq));
endmodule : arr_regs_monitor

bind arr_regs arr_regs_monitor mon (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .conv_start(conv_start), .range_code(range_code),
  .internal_reference_disable(internal_reference_disable), .range_valid(range_valid),
  .range_bipolar(range_bipolar), .overall_alarm(overall_alarm), .irq(irq));

/* sim/tb_arr_regs.sv */
// self-checking bench for the range-select and alarm register slice
// assumes arr_regs as dut on one 10 MHz clock; checker bound separately
`timescale 1ns/1ns
module tb_arr_regs;
  logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, conv_start = 0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, r, v;
  logic [3:0] pstrb = 4'hF, range_code, lat, pc, nw;
  logic pready, pslverr, irq, e, rdis, range_valid, range_bipolar, overall_alarm;
  logic internal_reference_disable;
  logic [3:0] tc [4] = '{4'h1, 4'h8, 4'h6, 4'h0};
  logic [4:0] tm [4] = '{5'h1F, 5'h00, 5'h1F, 5'h1F};
  arr_pkg::arr_alarm_t alarm_cond = '0;
  int errors = 0, n_compared = 0;
  always #50 clk = ~clk;
  arr_regs dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarm_cond(alarm_cond), .conv_start(conv_start),
    .range_code(range_code), .internal_reference_disable(internal_reference_disable),
    .range_valid(range_valid), .range_bipolar(range_bipolar),
    .overall_alarm(overall_alarm), .irq(irq));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // one idle edge first, so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
      @(posedge clk);
    while (pready !== 1'b1 && ++n < 20);
    if (n >= 20)
    begin
      errors++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic logic vld(input logic [3:0] c);
    return c <= 4'h4 || (c >= 4'h8 && c <= 4'hB);
  endfunction : vld
  function automatic logic [31:0] alm(input logic [3:0] c, input logic [3:0] l);
    return {16'h0, c[3:2], 2'h0, c[1:0], 2'h0, l, 3'h0, |l};
  endfunction : alm
  task automatic final_report();
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial
  begin
    #2000000;
    errors++;
    final_report();
  end
  initial
  begin
    void'($urandom(74264));
    repeat (6) @(posedge clk);
    rst <= 0;
    apb(0, 8'h14, 32'h0, r, e);
    chk(r, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 32'hFFFFFFFF : $urandom;
      apb(1, 8'h14, v, r, e);
      apb(0, 8'h14, 32'h0, r, e);
      chk(r, v & 32'h4F);
    end
    pstrb <= 4'h0;
    apb(1, 8'h14, ~v, r, e);
    pstrb <= 4'hF;
    apb(0, 8'h14, 32'h0, r, e);
    chk(r, v & 32'h4F);
    pc = 4'h0;
    for (int c = 0; c < 16; c++)
    begin
      rdis = $urandom;
      apb(1, 8'h14, {25'h0, rdis, 2'h0, 4'(c)}, r, e);
      chk({28'h0, range_code}, {28'h0, pc});
      @(posedge clk) conv_start <= 1;
      @(posedge clk) conv_start <= 0;
      repeat (2) @(posedge clk);
      pc = 4'(c);
      chk({25'h0, internal_reference_disable, range_valid, range_bipolar, range_code},
        {25'h0, rdis, vld(pc), ~pc[3], pc});
    end
    lat = 4'h0;
    foreach (tc[k])
    begin
      apb(1, 8'h30, {27'h0, tm[k]}, r, e);
      alarm_cond <= tc[k];
      repeat (10) @(posedge clk);
      nw = tc[k] & ~lat;
      v = {27'h0, nw, lat == 4'h0 && nw != 4'h0};
      chk({31'h0, irq}, {31'h0, |(v[4:0] & tm[k])});
      lat = lat | tc[k];
      chk({31'h0, overall_alarm}, {31'h0, |lat});
      apb(0, 8'h20, 32'h0, r, e);
      chk(r, alm(tc[k], lat));
      apb(0, 8'h34, 32'h0, r, e);
      chk(r, v);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    apb(1, 8'h20, 32'hFFFFFFFF, r, e);
    apb(0, 8'h20, 32'h0, r, e);
    chk(r, alm(4'h0, lat));
    apb(0, 8'h40, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    final_report();
  end
endmodule : tb_arr_regs

/* src/arr_params.svh */
// constants for the converter range-select and alarm register slice
// assumes inclusion by bare name from the modules
`ifndef ARR_PARAMS_SVH
`define ARR_PARAMS_SVH
`define ARR_ADDR_W 8
`define ARR_OFF_RANGE 8'h14
`define ARR_OFF_ALARM 8'h20
`define ARR_OFF_IRQ_MASK 8'h30
`define ARR_OFF_IRQ_STAT 8'h34
`define ARR_RNG_CODE_LSB 0
`define ARR_RNG_CODE_MSB 3
`define ARR_RNG_REFDIS_BIT 6
`define ARR_ALM_SUP_LOW_ACT 15
`define ARR_ALM_SUP_HIGH_ACT 14
`define ARR_ALM_IN_LOW_ACT 11
`define ARR_ALM_IN_HIGH_ACT 10
`define ARR_ALM_SUP_LOW_LAT 7
`define ARR_ALM_SUP_HIGH_LAT 6
`define ARR_ALM_IN_LOW_LAT 5
`define ARR_ALM_IN_HIGH_LAT 4
`define ARR_ALM_OVERALL 0
`define ARR_RNG_RESET 4'h0
`define ARR_ZERO32 32'h00000000
`define ARR_ZERO4 4'h0
`endif

/* src/arr_pkg.sv */
// types for the converter range-select and alarm register slice
// assumes arr_params.svh is on the include path
package arr_pkg;
  typedef struct packed {
    logic supply_low;
    logic supply_high;
    logic input_low;
    logic input_high;
  } arr_alarm_t;

  typedef struct packed {
    logic [3:0] range_code;
    logic internal_reference_disable;
  } arr_cfg_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } arr_apb_req_t;

  typedef enum logic [1:0] {
    ARR_IDLE,
    ARR_ACCESS
  } arr_bus_st_t;
endpackage : arr_pkg

/* src/arr_regs.sv */
// range-select and alarm register slice of a converter, APB slave
// assumes one 10 MHz clock, synchronous active-high reset, alarm
// condition inputs from analog comparators (asynchronous), conv_start
// from conversion logic on the same clock
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`include "arr_params.svh"
module arr_regs
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire arr_pkg::arr_alarm_t alarm_cond,
  input wire logic conv_start,
  output logic [3:0] range_code,
  output logic internal_reference_disable,
  output logic range_valid,
  output logic range_bipolar,
  output logic overall_alarm,
  output logic irq
);
  typedef struct packed {
    arr_pkg::arr_bus_st_t bus;
    arr_pkg::arr_cfg_t cfg;
    arr_pkg::arr_cfg_t conv_cfg;
    arr_pkg::arr_alarm_t latched;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic range_valid;
    logic range_bipolar;
    logic overall;
    logic irq;
  } arr_st_t;

  arr_st_t st_r;
  arr_st_t st_nxt;
  arr_pkg::arr_alarm_t live;

  arr_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(alarm_cond),
    .q(live)
  );

  // legal codes: five bipolar, four unipolar; others are not a documented range
  function automatic logic code_legal(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3, 4'h4: code_legal = 1'b1;
      4'h8, 4'h9, 4'hA, 4'hB: code_legal = 1'b1;
      default: code_legal = 1'b0;
    endcase
  endfunction : code_legal

  function automatic logic code_bipolar(input logic [3:0] c);
    code_bipolar = ~c[3];
  endfunction : code_bipolar

  function automatic logic [31:0] range_word(input arr_pkg::arr_cfg_t c);
    logic [31:0] w;
    w = `ARR_ZERO32;
    w[`ARR_RNG_CODE_MSB:`ARR_RNG_CODE_LSB] = c.range_code;
    w[`ARR_RNG_REFDIS_BIT] = c.internal_reference_disable;
    range_word = w;
  endfunction : range_word

  function automatic logic [31:0] alarm_word(input arr_pkg::arr_alarm_t act,
                                             input arr_pkg::arr_alarm_t lat);
    logic [31:0] w;
    w = `ARR_ZERO32;
    w[`ARR_ALM_SUP_LOW_ACT] = act.supply_low;
    w[`ARR_ALM_SUP_HIGH_ACT] = act.supply_high;
    // bit 11 carries the low-input name, bit 10 the high-input name
    w[`ARR_ALM_IN_LOW_ACT] = act.input_low;
    w[`ARR_ALM_IN_HIGH_ACT] = act.input_high;
    w[`ARR_ALM_SUP_LOW_LAT] = lat.supply_low;
    w[`ARR_ALM_SUP_HIGH_LAT] = lat.supply_high;
    w[`ARR_ALM_IN_LOW_LAT] = lat.input_low;
    w[`ARR_ALM_IN_HIGH_LAT] = lat.input_high;
    w[`ARR_ALM_OVERALL] = |lat;
    alarm_word = w;
  endfunction : alarm_word

  logic setup;
  logic access_wr;
  logic access_rd;
  logic [4:0] events;

  always_comb
  begin
    st_nxt = st_r;
    setup = psel & ~penable;
    access_wr = 1'b0;
    access_rd = 1'b0;
    // events: four alarm rises into latched flags plus the overall flag rising
    events = {live.supply_low & ~st_r.latched.supply_low,
              live.supply_high & ~st_r.latched.supply_high,
              live.input_low & ~st_r.latched.input_low,
              live.input_high & ~st_r.latched.input_high,
              1'b0};
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    case (st_r.bus)
      arr_pkg::ARR_IDLE:
      begin
        if (setup)
        begin
          st_nxt.bus = arr_pkg::ARR_ACCESS;
          st_nxt.pready = 1'b1;
          st_nxt.prdata = `ARR_ZERO32;
          if (!pwrite)
          begin
            case (paddr)
              `ARR_OFF_RANGE: st_nxt.prdata = range_word(st_r.cfg);
              `ARR_OFF_ALARM: st_nxt.prdata = alarm_word(live, st_r.latched);
              `ARR_OFF_IRQ_MASK: st_nxt.prdata = {27'h0000000, st_r.irq_mask};
              `ARR_OFF_IRQ_STAT: st_nxt.prdata = {27'h0000000, st_r.irq_stat};
              default: st_nxt.pslverr = 1'b1;
            endcase
          end
          else
          begin
            case (paddr)
              `ARR_OFF_RANGE, `ARR_OFF_ALARM, `ARR_OFF_IRQ_MASK, `ARR_OFF_IRQ_STAT:
                st_nxt.pslverr = 1'b0;
              default: st_nxt.pslverr = 1'b1;
            endcase
          end
        end
      end
      arr_pkg::ARR_ACCESS:
      begin
        // answer was prepared in setup; pready is high in this access cycle
        st_nxt.bus = arr_pkg::ARR_IDLE;
        access_wr = psel & penable & pwrite;
        access_rd = psel & penable & ~pwrite;
      end
      default: st_nxt.bus = arr_pkg::ARR_IDLE;
    endcase

    if (access_wr && paddr == `ARR_OFF_RANGE && pstrb[0])
    begin
      // only bits 6 and 3..0 are storage; other bits are dropped
      st_nxt.cfg.range_code = pwdata[`ARR_RNG_CODE_MSB:`ARR_RNG_CODE_LSB];
      st_nxt.cfg.internal_reference_disable = pwdata[`ARR_RNG_REFDIS_BIT];
    end
    if (access_wr && paddr == `ARR_OFF_IRQ_MASK && pstrb[0])
    begin
      st_nxt.irq_mask = pwdata[4:0];
    end

    // latched flags never clear except by reset; writes to alarms ignored
    st_nxt.latched = st_r.latched | live;
    st_nxt.overall = |st_nxt.latched;
    events[0] = st_nxt.overall & ~st_r.overall;

    // read clears, but a new event in the same cycle wins
    if (access_rd && paddr == `ARR_OFF_IRQ_STAT)
    begin
      st_nxt.irq_stat = events;
    end
    else
    begin
      st_nxt.irq_stat = st_r.irq_stat | events;
    end
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);

    // conversion logic samples the setting at its start, so a write never
    // disturbs a conversion already running
    if (conv_start)
    begin
      st_nxt.conv_cfg = st_r.cfg;
    end
    st_nxt.range_valid = code_legal(st_nxt.conv_cfg.range_code);
    st_nxt.range_bipolar = code_bipolar(st_nxt.conv_cfg.range_code);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.bus <= arr_pkg::ARR_IDLE;
      st_r.range_valid <= 1'b1;
      st_r.range_bipolar <= 1'b1;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign range_code = st_r.conv_cfg.range_code;
  assign internal_reference_disable = st_r.conv_cfg.internal_reference_disable;
  assign range_valid = st_r.range_valid;
  assign range_bipolar = st_r.range_bipolar;
  assign overall_alarm = st_r.overall;
  assign irq = st_r.irq;
endmodule : arr_regs

/* src/arr_sync.sv */
// three-stage synchroniser array for asynchronous alarm inputs
// assumes clk, rst synchronous; a change counts when stages two and three agree
`timescale 1ns/1ns
`include "arr_params.svh"
module arr_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire arr_pkg::arr_alarm_t d,
  output arr_pkg::arr_alarm_t q
);
  typedef struct packed {
    arr_pkg::arr_alarm_t s1;
    arr_pkg::arr_alarm_t s2;
    arr_pkg::arr_alarm_t s3;
    arr_pkg::arr_alarm_t q;
  } arr_sync_st_t;

  arr_sync_st_t st_r;
  arr_sync_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // output moves only when the two later stages agree
    if (st_r.s2 == st_r.s3)
    begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_r <= '0;
    end
    else if (ce)
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;
endmodule : arr_sync
